// [hdl/fsw_range_check.v]
// Purpose: Decides whether a program or erase target range is protected.
// Assumes: Start address may be unaligned; it is aligned here by the kind.
// Notes: Pure combinational check.
`timescale 1ns/100ps
`include "fsw_regs.vh"

module fsw_range_check (
    op_kind,
    op_addr,
    level,
    top_lock,
    bot_lock,
    blocked
);
    input wire [2:0] op_kind;
    input wire [17:0] op_addr;
    input wire [1:0] level;
    input wire top_lock;
    input wire bot_lock;
    output reg blocked;

    reg [17:0] lo;
    reg [17:0] hi;
    reg [17:0] prot_lo;
    reg prot_any;

    // Align the start and size the range from the operation kind.
    always @* begin
        lo = op_addr;
        hi = op_addr;
        case (op_kind)
            `FSW_OP_SECTOR: begin
                lo = op_addr & ~`FSW_SZ_SECTOR;
                hi = lo | `FSW_SZ_SECTOR;
            end
            `FSW_OP_BLK32: begin
                lo = op_addr & ~`FSW_SZ_BLK32;
                hi = lo | `FSW_SZ_BLK32;
            end
            `FSW_OP_BLK64: begin
                lo = op_addr & ~`FSW_SZ_BLK64;
                hi = lo | `FSW_SZ_BLK64;
            end
            `FSW_OP_CHIP: begin
                lo = {`FSW_AW{1'b0}};
                hi = `FSW_ADDR_MAX;
            end
            `FSW_OP_AUTO: begin
                lo = op_addr & ~`FSW_SZ_AUTO;
                hi = lo | `FSW_SZ_AUTO;
            end
            default: begin
                lo = op_addr;
                hi = op_addr;
            end
        endcase
        // Protected region always runs to the top of the array.
        prot_any = 1'b1;
        prot_lo = {`FSW_AW{1'b0}};
        case (level)
            `FSW_LVL_NONE: prot_any = 1'b0;
            `FSW_LVL_QTR: prot_lo = `FSW_ADDR_TOP_QTR;
            `FSW_LVL_HALF: prot_lo = `FSW_ADDR_TOP_HALF;
            default: prot_lo = {`FSW_AW{1'b0}};
        endcase
        blocked = (prot_any && (hi >= prot_lo))
            || (top_lock && (hi >= (`FSW_ADDR_MAX - `FSW_SZ_SECTOR)))
            || (bot_lock && (lo < `FSW_SECTOR_BYTES))
            || ((op_kind == `FSW_OP_CHIP) && (level != `FSW_LVL_NONE));
    end
endmodule

// [hdl/fsw_regs.vh]
// Purpose: Constants for the flash status and write-protect block.
// Assumes: Included by every design file of the block.
// Notes: Register selects, field positions, reset values and ranges are named here.
`ifndef FSW_REGS_VH
`define FSW_REGS_VH

// ****************************************************************
// Register selects and field positions
// ****************************************************************
`define FSW_SEL_MAIN 1'b0
`define FSW_SEL_SECT 1'b1
`define FSW_BIT_BUSY 0
`define FSW_BIT_WEL 1
`define FSW_BIT_LVL_LO 2
`define FSW_BIT_LVL_HI 3
`define FSW_BIT_AUTO 6
`define FSW_BIT_LOCK 7
`define FSW_BIT_TOP 2
`define FSW_BIT_BOT 3

// ****************************************************************
// Reset values
// ****************************************************************
`define FSW_RST_LEVEL 2'h3
`define FSW_RST_ZERO 1'b0

// ****************************************************************
// Array geometry, 18-bit byte address
// ****************************************************************
`define FSW_AW 18
`define FSW_ADDR_TOP_QTR 18'h30000
`define FSW_ADDR_TOP_HALF 18'h20000
`define FSW_ADDR_MAX 18'h3ffff
`define FSW_SECTOR_BYTES 18'h01000
`define FSW_LVL_NONE 2'h0
`define FSW_LVL_QTR 2'h1
`define FSW_LVL_HALF 2'h2
`define FSW_LVL_FULL 2'h3

// ****************************************************************
// Operation kinds requested by the instruction decoder
// ****************************************************************
`define FSW_OP_BYTE 3'h0
`define FSW_OP_AUTO 3'h1
`define FSW_OP_SECTOR 3'h2
`define FSW_OP_BLK32 3'h3
`define FSW_OP_BLK64 3'h4
`define FSW_OP_CHIP 3'h5
`define FSW_SZ_SECTOR 18'h00fff
`define FSW_SZ_BLK32 18'h07fff
`define FSW_SZ_BLK64 18'h0ffff
`define FSW_SZ_AUTO 18'h00001

`endif

// [hdl/fsw_status_protect.v]
// Purpose: Status registers and write-protection gate of a serial flash.
// Assumes: An instruction decoder delivers one-cycle completion strobes,
//          and an engine reports busy and completions on core_clk.
// Notes: Status bytes are read live; writes arrive as whole bytes.
`timescale 1ns/100ps
`include "fsw_regs.vh"

module fsw_status_protect (
    core_clk,
    arst_n,
    wp_n_pin,
    write_enable_cmd,
    write_disable_cmd,
    status_write_cmd,
    status_write_sel,
    status_write_data,
    op_req,
    op_kind,
    op_addr,
    op_busy,
    op_done,
    auto_mode_enter,
    auto_mode_exit,
    main_status,
    sector_lock_status,
    op_grant,
    op_reject,
    status_write_reject
);
    input wire core_clk;
    input wire arst_n;
    input wire wp_n_pin;
    input wire write_enable_cmd;
    input wire write_disable_cmd;
    input wire status_write_cmd;
    input wire status_write_sel;
    input wire [7:0] status_write_data;
    input wire op_req;
    input wire [2:0] op_kind;
    input wire [17:0] op_addr;
    input wire op_busy;
    input wire op_done;
    input wire auto_mode_enter;
    input wire auto_mode_exit;
    output reg [7:0] main_status;
    output reg [7:0] sector_lock_status;
    output reg op_grant;
    output reg op_reject;
    output reg status_write_reject;

    // ****************************************************************
    // State
    // ****************************************************************
    reg busy_q;
    reg wel_q;
    reg wel_d;
    reg auto_q;
    reg auto_d;
    reg [1:0] level_q;
    reg [1:0] level_d;
    reg lock_q;
    reg lock_d;
    reg top_q;
    reg top_d;
    reg bot_q;
    reg bot_d;
    wire wp_n_sync;
    wire range_blocked;
    wire sw_allowed;
    wire sw_go;
    wire op_go;

    // Returns 1 when protection bits are frozen by pin and lock.
    function frozen;
        input wp_n;
        input lock;
        begin
            frozen = (!wp_n) && lock;
        end
    endfunction

    fsw_sync u_wp_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pin_in(wp_n_pin),
        .pin_sync(wp_n_sync)
    );

    fsw_range_check u_range (
        .op_kind(op_kind),
        .op_addr(op_addr),
        .level(level_q),
        .top_lock(top_q),
        .bot_lock(bot_q),
        .blocked(range_blocked)
    );

    // ****************************************************************
    // Acceptance decisions
    // ****************************************************************
    // Status write needs the latch, an idle engine, and no lock-down.
    assign sw_allowed = !frozen(wp_n_sync, lock_q);
    assign sw_go = status_write_cmd && wel_q && !busy_q && sw_allowed;
    // Program and erase need the latch and an unprotected range.
    assign op_go = op_req && wel_q && !busy_q && !range_blocked;

    // Next values of the protection fields on an accepted status write.
    always @* begin
        level_d = level_q;
        lock_d = lock_q;
        top_d = top_q;
        bot_d = bot_q;
        if (sw_go) begin
            if (status_write_sel == `FSW_SEL_MAIN) begin
                level_d = {status_write_data[`FSW_BIT_LVL_HI],
                           status_write_data[`FSW_BIT_LVL_LO]};
                lock_d = status_write_data[`FSW_BIT_LOCK];
            end else begin
                top_d = status_write_data[`FSW_BIT_TOP];
                bot_d = status_write_data[`FSW_BIT_BOT];
            end
        end
    end

    // Auto-increment flag: enter wins, so the status image shows it one cycle after the pulse.
    always @* begin
        auto_d = auto_q;
        if (auto_mode_enter) begin
            auto_d = 1'b1;
        end else if (auto_mode_exit) begin
            auto_d = 1'b0;
        end
    end

    // Latch: disable and completions win over enable in the same cycle.
    always @* begin
        wel_d = wel_q;
        if (write_enable_cmd && !busy_q) begin
            wel_d = 1'b1;
        end
        if (write_disable_cmd || status_write_cmd || op_done) begin
            wel_d = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Protection and latch state.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wel_q <= `FSW_RST_ZERO;
            level_q <= `FSW_RST_LEVEL;
            lock_q <= `FSW_RST_ZERO;
            top_q <= `FSW_RST_ZERO;
            bot_q <= `FSW_RST_ZERO;
        end else begin
            wel_q <= wel_d;
            level_q <= level_d;
            lock_q <= lock_d;
            top_q <= top_d;
            bot_q <= bot_d;
        end
    end

    // Busy follows the engine, and also covers a just-granted operation.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= `FSW_RST_ZERO;
            auto_q <= `FSW_RST_ZERO;
        end else begin
            busy_q <= op_go || (op_busy && !op_done);
            auto_q <= auto_d;
        end
    end

    // Registered outputs: status images and decision strobes.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            main_status <= {`FSW_RST_ZERO, `FSW_RST_ZERO, 2'h0, `FSW_RST_LEVEL, 2'h0};
            sector_lock_status <= 8'h00;
            op_grant <= 1'b0;
            op_reject <= 1'b0;
            status_write_reject <= 1'b0;
        end else begin
            main_status <= {lock_d, auto_d, 2'h0, level_d, wel_d,
                            (op_go || (op_busy && !op_done))};
            sector_lock_status <= {4'h0, bot_d, top_d, 2'h0};
            op_grant <= op_go;
            op_reject <= op_req && !op_go;
            status_write_reject <= status_write_cmd && !sw_go;
        end
    end
endmodule

// [hdl/fsw_sync.v]
// Purpose: Two-flop synchroniser for the write-protect pin.
// Assumes: Pin is asynchronous to core_clk.
// Notes: First flop feeds only the second.
`timescale 1ns/100ps
`include "fsw_regs.vh"

module fsw_sync (
    core_clk,
    arst_n,
    pin_in,
    pin_sync
);
    input wire core_clk;
    input wire arst_n;
    input wire pin_in;
    output reg pin_sync;

    reg meta_q;

    // ****************************************************************
    // Synchroniser
    // ****************************************************************
    // Resets high, so protection stays relaxed until a real sample arrives.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            meta_q <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule

// [tb/fsw_checker.sv]
// Purpose: Port checks for the status and protect block.
// Assumes: Answers land one cycle after a pulse.
// Notes: Pin rules wait four cycles to cover the pin synchroniser.
`timescale 1ns/100ps
module fsw_checker (
    input wire core_clk,
    input wire arst_n,
    input wire wp_n_pin,
    input wire write_enable_cmd,
    input wire write_disable_cmd,
    input wire status_write_cmd,
    input wire status_write_sel,
    input wire [7:0] status_write_data,
    input wire op_req,
    input wire [2:0] op_kind,
    input wire op_done,
    input wire auto_mode_enter,
    input wire [7:0] main_status,
    input wire [7:0] sector_lock_status,
    input wire op_grant,
    input wire op_reject,
    input wire status_write_reject
);
    reg [7:0] wdat_q;

    // Keeps the written byte for the cycle after the write.
    always @(posedge core_clk) begin
        wdat_q <= status_write_data;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_pin_low;
        !wp_n_pin [*4];
    endsequence
    sequence s_pin_high;
        wp_n_pin [*4];
    endsequence

    a_reserved_zero: assert property (
        {main_status[5:4], sector_lock_status[7:4], sector_lock_status[1:0]} == 8'h00)
        else $error("reserved bits set");
    a_locked_write: assert property (
        s_pin_low ##0 (status_write_cmd && main_status[7]) |=> status_write_reject
        && $stable({main_status[7], main_status[3:2], sector_lock_status}))
        else $error("locked write taken");
    a_open_write: assert property (
        s_pin_high ##0 (status_write_cmd && !status_write_sel && main_status[1] && !main_status[0])
        |=> !status_write_reject && {main_status[7], main_status[3:2]} == {wdat_q[7], wdat_q[3:2]})
        else $error("open write lost");
    a_no_latch: assert property (
        op_req && !main_status[1] |=> op_reject && !op_grant) else $error("op without latch");
    a_latch_set: assert property (
        write_enable_cmd && !write_disable_cmd && !status_write_cmd && !op_done && !op_req
        && !main_status[0] |=> main_status[1]) else $error("latch not set");
    a_latch_clear: assert property (
        write_disable_cmd || status_write_cmd || op_done |=> !main_status[1])
        else $error("latch not cleared");
    a_full_level: assert property (
        op_req && main_status[3:2] == 2'h3 |=> op_reject) else $error("full level granted");
    a_chip_level: assert property (
        op_req && op_kind == 3'h5 && main_status[3:2] != 2'h0 |=> op_reject)
        else $error("chip erase granted");
    a_grant_busy: assert property (
        op_grant |-> main_status[0]) else $error("busy not shown");
    a_auto_flag: assert property (
        auto_mode_enter |=> main_status[6]) else $error("auto flag not set");
endmodule

bind fsw_status_protect fsw_checker chk (.core_clk(core_clk), .arst_n(arst_n),
    .wp_n_pin(wp_n_pin), .write_enable_cmd(write_enable_cmd),
    .write_disable_cmd(write_disable_cmd), .status_write_cmd(status_write_cmd),
    .status_write_sel(status_write_sel), .status_write_data(status_write_data),
    .op_req(op_req), .op_kind(op_kind), .op_done(op_done), .auto_mode_enter(auto_mode_enter),
    .main_status(main_status), .sector_lock_status(sector_lock_status),
    .op_grant(op_grant), .op_reject(op_reject), .status_write_reject(status_write_reject));

// [tb/fsw_host.sv]
// Purpose: Host and engine model on the far side of the block.
// Assumes: Answers are read one cycle after the pulse edge.
// Notes: Released data and address are inverted so stale values never pass.
`timescale 1ns/100ps
module fsw_host (
    input wire core_clk,
    input wire op_grant,
    input wire status_write_reject,
    output reg write_enable_cmd = 1'b0,
    output reg write_disable_cmd = 1'b0,
    output reg status_write_cmd = 1'b0,
    output reg status_write_sel = 1'b0,
    output reg [7:0] status_write_data = 8'h00,
    output reg op_req = 1'b0,
    output reg [2:0] op_kind = 3'h0,
    output reg [17:0] op_addr = 18'h00000,
    output reg op_busy = 1'b0,
    output reg op_done = 1'b0,
    output reg auto_mode_enter = 1'b0,
    output reg auto_mode_exit = 1'b0
);
    // Sends 0 enable, 1 disable, 2 auto on, 3 auto off, 4 status write, 5 operation.
    task send(input integer w, input [17:0] v, input [2:0] k, output ans);
        begin
            @(posedge core_clk);
            write_enable_cmd <= (w == 0);
            write_disable_cmd <= (w == 1);
            auto_mode_enter <= (w == 2);
            auto_mode_exit <= (w == 3);
            status_write_cmd <= (w == 4);
            op_req <= (w == 5);
            status_write_sel <= k[0];
            status_write_data <= v[7:0];
            op_kind <= k;
            op_addr <= v;
            @(posedge core_clk);
            {write_enable_cmd, write_disable_cmd, auto_mode_enter} <= 3'h0;
            {auto_mode_exit, status_write_cmd, op_req} <= 3'h0;
            status_write_data <= ~v[7:0];
            op_addr <= ~v;
            #1 ans = (w == 5) ? op_grant : status_write_reject;
            // The engine runs three cycles and the host only waits meanwhile.
            if (w == 5 && ans) begin
                @(posedge core_clk);
                op_busy <= 1'b1;
                repeat (3) @(posedge core_clk);
                op_busy <= 1'b0;
                op_done <= 1'b1;
                @(posedge core_clk);
                op_done <= 1'b0;
            end
            repeat (2) @(posedge core_clk);
            #1;
        end
    endtask
endmodule

// [tb/fsw_status_protect_test.sv]
// Purpose: Seeded random walk of the block against a bench model.
// Assumes: Four idle cycles follow every pin change.
// Notes: Status images are compared after every step.
`timescale 1ns/100ps
module fsw_status_protect_test;
    reg core_clk = 1'b0;
    reg arst_n = 1'b0;
    reg wp_n_pin = 1'b1;
    wire [7:0] ms, ss, wdat;
    wire [17:0] addr;
    wire [2:0] kind;
    wire wen, wdis, wsc, wsel, req, busy, done, aen, aex, gnt, rej, srej;
    integer error_cnt = 0, n_tests = 0, seed = 84;
    integer lvl = 3, lock = 0, top = 0, bot = 0, write_enable_latch = 0, auf = 0;
    integer i, r, ps, lo, hi, m;
    reg ans, e;
    reg [17:0] a;
    reg [2:0] k;

    always #10 core_clk = ~core_clk;

    fsw_status_protect dut (.core_clk(core_clk), .arst_n(arst_n), .wp_n_pin(wp_n_pin),
        .write_enable_cmd(wen), .write_disable_cmd(wdis), .status_write_cmd(wsc),
        .status_write_sel(wsel), .status_write_data(wdat), .op_req(req), .op_kind(kind),
        .op_addr(addr), .op_busy(busy), .op_done(done), .auto_mode_enter(aen),
        .auto_mode_exit(aex), .main_status(ms), .sector_lock_status(ss),
        .op_grant(gnt), .op_reject(rej), .status_write_reject(srej));
    fsw_host host (.core_clk(core_clk), .op_grant(gnt), .status_write_reject(srej),
        .write_enable_cmd(wen), .write_disable_cmd(wdis), .status_write_cmd(wsc),
        .status_write_sel(wsel), .status_write_data(wdat), .op_req(req), .op_kind(kind),
        .op_addr(addr), .op_busy(busy), .op_done(done), .auto_mode_enter(aen),
        .auto_mode_exit(aex));

    // Compares one value and counts it.
    task check(input [127:0] nm, input [17:0] ex, input [17:0] s);
        begin
            n_tests = n_tests + 1;
            if (ex !== s) begin
                error_cnt = error_cnt + 1;
                $display("mismatch %0s expected %h seen %h", nm, ex, s);
            end
        end
    endtask

    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // Model verdict on a program or erase request.
    function blocked(input [2:0] kk, input [17:0] aa);
        begin
            m = (kk == 5) ? 'h3ffff : (kk == 4) ? 'hffff : (kk == 3) ? 'h7fff : (kk == 2) ? 'hfff : kk;
            lo = aa & ~m;
            hi = lo | m;
            ps = (lvl == 3) ? 0 : 'h40000 - lvl * 'h10000;
            blocked = !write_enable_latch || hi >= ps || (kk == 5 && lvl != 0) || (top && hi >= 'h3f000)
                || (bot && lo < 'h1000);
        end
    endfunction

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt = error_cnt + 1;
        finish_test;
    end

    // Resets, checks reset images, then walks random steps.
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        check("main", 18'h0c, ms);
        check("sector", 18'h0, ss);
        $display("test done: reset values");
        for (i = 0; i < 400; i = i + 1) begin
            r = $random(seed);
            a = $random(seed);
            k = r[15:8] % 6;
            if (r[4:3] == 2'h0) begin
                @(posedge core_clk);
                wp_n_pin <= r[5];
                repeat (4) @(posedge core_clk);
            end
            if (r[6] && r[2]) begin
                host.send(0, a, k, ans);
                write_enable_latch = 1;
            end
            case (r[2:0])
                3'h0: begin
                    host.send(1, a, k, ans);
                    write_enable_latch = 0;
                end
                3'h1: begin
                    host.send(r[7] ? 2 : 3, a, k, ans);
                    auf = r[7];
                end
                3'h4, 3'h5: begin
                    e = !write_enable_latch || (!wp_n_pin && lock);
                    host.send(4, a, k, ans);
                    if (!e && k[0]) begin
                        top = a[2];
                        bot = a[3];
                    end else if (!e) begin
                        lock = a[7];
                        lvl = a[3:2];
                    end
                    write_enable_latch = 0;
                    check("wr_reject", e, ans);
                end
                3'h6, 3'h7: begin
                    e = blocked(k, a);
                    host.send(5, a, k, ans);
                    if (!e) write_enable_latch = 0;
                    check("op_grant", !e, ans);
                end
                default: begin
                    host.send(0, a, k, ans);
                    write_enable_latch = 1;
                end
            endcase
            check("main", lock * 128 + auf * 64 + lvl * 4 + write_enable_latch * 2, ms);
            check("sector", top * 4 + bot * 8, ss);
        end
        $display("test done: random walk");
        finish_test;
    end
endmodule
